//--- design/audio_ctrl_defs.svh
// Offsets, field limits, reset values and timing counts for the audio control bank.
// Assumes the includer runs at 200 MHz.
`ifndef AUDIO_CTRL_DEFS_SVH
`define AUDIO_CTRL_DEFS_SVH

`define ADDR_PLL_FRACTION 7'h1C
`define ADDR_CTRL_FOUR 7'h1D
`define ADDR_CTRL_FIVE 7'h1E

`define FRACTION_MAX 14'h270F
`define CEILING_MAX 7'h77
`define CEILING_RESET 7'h7F
`define HYST_NONE 2'h3

`define CLOCK_MHZ 200
`define DEB_STEP_US 500
`define DEB_STEP_CYCLES (`DEB_STEP_US * `CLOCK_MHZ)
`define RAMP_SHORT_US 1000
`define RAMP_LONG_US 5000
`define RAMP_SHORT_NOVG_US 800000
`define RAMP_LONG_NOVG_US 4000000
`define US_CYCLES 200

`endif

//--- design/audio_ctrl_pkg.sv
// Types shared by the audio control bank.
// Assumes audio_ctrl_defs.svh is available to modules.
package audio_ctrl_pkg;
    typedef struct packed {
        logic [13:0] pll_fraction_field;
    } fraction_reg_t;

    typedef struct packed {
        logic record_gain_step_off;
        logic playback_gain_step_off;
        logic analog_sidetone_step_off;
        logic digital_sidetone_zc_off;
        logic [1:0] gain_ctrl_hysteresis;
        logic short_detect_off;
        logic short_auto_powerdown;
        logic playback_pop_speed;
        logic [1:0] playback_pop_length;
    } ctrl_four_t;

    typedef struct packed {
        logic [6:0] gain_ctrl_ceiling;
        logic [2:0] to_silence_debounce;
        logic [2:0] to_speech_debounce;
        logic driver_pop_cut_off;
        logic driver_ramp_length;
    } ctrl_five_t;

    typedef enum logic [1:0] {
        RAMP_IDLE = 2'b00,
        RAMP_RUN = 2'b01,
        RAMP_DONE = 2'b11
    } ramp_state_t;
endpackage : audio_ctrl_pkg

//--- design/audio_pll_agc_control_regs.sv
// Audio PLL fraction and AGC/driver control register bank, reached by 16-bit
// word reads and writes from the host serial port front end.
// Assumes the serial port delivers synchronous one-cycle strobes.
// Operation
// - Fraction field sits in bits 15..2; values over 9999 act as 9999.
// - Fraction reaches the PLL only while the PLL is enabled.
// - Fraction register low two bits are reserved, read zero.
// - Bits 15..13 disable record, playback and analog sidetone soft-stepping.
// - Bit 12 disables digital sidetone zero-cross gain changes.
// - Bits 10..9 pick AGC hysteresis 1, 2, 4 dB or none.
// - Bit 8 turns short-circuit detection off.
// - Bit 7 powers drivers down automatically on a detected short.
// - Read-only bit 6 reports a detected short, reset zero.
// - Read-only bit 5 reports playback pop reduction enabled.
// - Bit 4 selects fast or slow ramp; bits 3..2 long or short.
// - Bits 15..9 cap AGC gain in 0.5 dB steps, max 59.5 dB.
// - Bits 8..6 set speech-to-silence debounce time.
// - Bits 5..3 set silence-to-speech debounce, same mapping.
// - Bit 2 of the second word disables driver pop reduction.
// - Bit 1 picks 1 ms or 5 ms ramp, 0.8 s or 4 s without ground.
`timescale 1ns/1ps
`default_nettype none
`include "audio_ctrl_defs.svh"
module audio_pll_agc_control_regs
    import audio_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register access from the serial port
    input wire logic [6:0] reg_addr,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    // Device status
    input wire logic pll_enable,
    input wire logic [1:0] page_marker,
    input wire logic short_raw,
    input wire logic playback_pop_active,
    input wire logic driver_power_up,
    input wire logic virtual_ground,
    input wire logic agc_speech_now,
    // Controls to the analog and gain logic
    output logic [13:0] pll_fraction,
    output logic [3:0] step_off,
    output logic [1:0] gain_ctrl_hysteresis,
    output logic [6:0] gain_ctrl_ceiling,
    output logic agc_speech_mode,
    output logic driver_powerdown,
    output logic short_seen_flag,
    output logic [2:0] playback_pop_cfg,
    output logic driver_ramping
);
    // 0.5 ms step; 32 ms top code needs 23 bits of count
    localparam logic [22:0] DEB_STEP = 23'(`DEB_STEP_CYCLES);

    fraction_reg_t fraction;
    ctrl_four_t four;
    ctrl_five_t five;
    logic playback_pop_cut_on;
    logic [22:0] deb_count;
    logic ramp_start;
    wire logic ramping;

    // Debounce code to 0.5 ms units: 0, 1, 2, 4, 8, 16, 32, 64
    function automatic logic [22:0] debounce_cycles(input logic [2:0] code);
        logic [6:0] units;
        units = (code == 3'h0) ? 7'h00 : 7'(7'h01 << (code - 3'h1));
        return 23'(units * DEB_STEP);
    endfunction : debounce_cycles

    // Fraction and ceiling both saturate at their top code
    function automatic logic [13:0] clamp14(input logic [13:0] v, input logic [13:0] top);
        return (v > top) ? top : v;
    endfunction : clamp14

    wire logic hit_frac = (reg_addr == `ADDR_PLL_FRACTION);
    wire logic hit_four = (reg_addr == `ADDR_CTRL_FOUR);
    wire logic hit_five = (reg_addr == `ADDR_CTRL_FIVE);
    wire logic short_event = short_raw && !four.short_detect_off;
    wire logic [13:0] frac_eff = clamp14(fraction.pll_fraction_field, `FRACTION_MAX);
    wire logic [6:0] ceil_eff = 7'(clamp14({7'h00, five.gain_ctrl_ceiling},
                                           {7'h00, `CEILING_MAX}));
    wire logic speech_target = agc_speech_now;
    wire logic [22:0] deb_limit = agc_speech_mode ? debounce_cycles(five.to_silence_debounce)
                                                  : debounce_cycles(five.to_speech_debounce);
    wire logic [15:0] rd_frac = {fraction.pll_fraction_field, 2'b00};
    wire logic [15:0] rd_four = {four.record_gain_step_off, four.playback_gain_step_off,
                                 four.analog_sidetone_step_off, four.digital_sidetone_zc_off,
                                 1'b0, four.gain_ctrl_hysteresis, four.short_detect_off,
                                 four.short_auto_powerdown, short_seen_flag,
                                 playback_pop_cut_on, four.playback_pop_speed,
                                 four.playback_pop_length, page_marker};
    wire logic [15:0] rd_five = {five, 1'b0};
    wire logic [15:0] next_rdata = hit_frac ? rd_frac : hit_four ? rd_four
                                 : hit_five ? rd_five : 16'h0000;

    // Register writes; read-only and reserved positions are never taken
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            fraction <= '0;
            four <= '0;
            five <= {`CEILING_RESET, 3'h0, 3'h0, 1'b0, 1'b0};
        end else if (reg_write) begin
            if (hit_frac)
                fraction.pll_fraction_field <= reg_wdata[15:2];
            if (hit_four)
                four <= {reg_wdata[15:12], reg_wdata[10:7], reg_wdata[4:2]};
            if (hit_five)
                five <= reg_wdata[15:1];
        end
    end

    // Read port answers one cycle after the strobe
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_read;
            if (reg_read)
                reg_rdata <= next_rdata;
        end
    end

    // Short flag follows live detection; driver power-down latches until cleared
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            short_seen_flag <= 1'b0;
            driver_powerdown <= 1'b0;
        end else begin
            short_seen_flag <= short_event;
            if (short_event && four.short_auto_powerdown)
                driver_powerdown <= 1'b1;
            else if (!four.short_auto_powerdown || driver_power_up)
                driver_powerdown <= 1'b0;
        end
    end

    // AGC mode change only after the selected debounce has held
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            agc_speech_mode <= 1'b0;
            deb_count <= 23'h0;
        end else if (speech_target == agc_speech_mode) begin
            deb_count <= 23'h0;
        end else if (deb_count >= deb_limit) begin
            agc_speech_mode <= speech_target;
            deb_count <= 23'h0;
        end else begin
            deb_count <= deb_count + 23'h1;
        end
    end

    // Registered control outputs
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pll_fraction <= 14'h0;
            step_off <= 4'h0;
            gain_ctrl_hysteresis <= 2'h0;
            gain_ctrl_ceiling <= `CEILING_MAX;
            playback_pop_cfg <= 3'h0;
            playback_pop_cut_on <= 1'b0;
            ramp_start <= 1'b0;
            driver_ramping <= 1'b0;
        end else begin
            pll_fraction <= pll_enable ? frac_eff : 14'h0;
            step_off <= {four.record_gain_step_off, four.playback_gain_step_off,
                         four.analog_sidetone_step_off,
                         four.digital_sidetone_zc_off};
            gain_ctrl_hysteresis <= four.gain_ctrl_hysteresis;
            gain_ctrl_ceiling <= ceil_eff;
            playback_pop_cfg <= {four.playback_pop_speed, four.playback_pop_length};
            playback_pop_cut_on <= playback_pop_active;
            ramp_start <= driver_power_up;
            driver_ramping <= ramping;
        end
    end

    // Ramp timer; no ramp when pop reduction is off
    driver_ramp ramp_u (
        .clock(clock),
        .rst_n(rst_n),
        .start(ramp_start),
        .pop_cut_off(five.driver_pop_cut_off),
        .long_ramp(five.driver_ramp_length),
        .virtual_ground(virtual_ground),
        .ramping(ramping)
    );

    fraction_clamp_a: assert property (@(posedge clock) disable iff (!rst_n)
        pll_enable |=> pll_fraction <= `FRACTION_MAX)
        else $error("fraction above limit");
    pll_off_a: assert property (@(posedge clock) disable iff (!rst_n)
        !pll_enable |=> pll_fraction == 14'h0)
        else $error("fraction applied with pll off");
    frac_low_a: assert property (@(posedge clock) disable iff (!rst_n)
        reg_read && hit_frac |=> reg_rdata[1:0] == 2'b00)
        else $error("reserved bits nonzero");
    step_follow_a: assert property (@(posedge clock) disable iff (!rst_n)
        reg_write && hit_four |=> ##1 step_off[3:1] == $past(reg_wdata[15:13], 2))
        else $error("step controls wrong");
    short_off_a: assert property (@(posedge clock) disable iff (!rst_n)
        four.short_detect_off |=> !short_seen_flag)
        else $error("short seen while detection off");
    auto_pd_a: assert property (@(posedge clock) disable iff (!rst_n)
        short_event && four.short_auto_powerdown |=> driver_powerdown)
        else $error("no power down on short");
    no_pd_a: assert property (@(posedge clock) disable iff (!rst_n)
        !four.short_auto_powerdown |=> !driver_powerdown)
        else $error("power down while disabled");
    ceiling_cap_a: assert property (@(posedge clock) disable iff (!rst_n)
        gain_ctrl_ceiling <= `CEILING_MAX)
        else $error("ceiling above 59.5 dB");
    five_low_a: assert property (@(posedge clock) disable iff (!rst_n)
        reg_read && hit_five |=> reg_rdata[0] == 1'b0)
        else $error("reserved bit nonzero");
    frac_apply_a: assert property (@(posedge clock) disable iff (!rst_n)
        pll_enable && (fraction.pll_fraction_field <= `FRACTION_MAX)
        |=> pll_fraction == $past(fraction.pll_fraction_field))
        else $error("fraction not applied as written");
    hyst_follow_a: assert property (@(posedge clock) disable iff (!rst_n)
        reg_write && hit_four |=> ##1 gain_ctrl_hysteresis == $past(reg_wdata[10:9], 2))
        else $error("hysteresis code wrong");
    pop_cfg_a: assert property (@(posedge clock) disable iff (!rst_n)
        reg_write && hit_four |=> ##1 playback_pop_cfg == $past(reg_wdata[4:2], 2))
        else $error("pop reduction setting wrong");
    four_status_a: assert property (@(posedge clock) disable iff (!rst_n)
        reg_read && hit_four |=> reg_rdata[11] == 1'b0
            && reg_rdata[6] == $past(short_seen_flag)
            && reg_rdata[5] == $past(playback_pop_cut_on))
        else $error("status bits wrong in readback");
    ceiling_write_a: assert property (@(posedge clock) disable iff (!rst_n)
        reg_write && hit_five |=> ##1 gain_ctrl_ceiling
            == (($past(reg_wdata[15:9], 2) > `CEILING_MAX) ? `CEILING_MAX
                : $past(reg_wdata[15:9], 2)))
        else $error("ceiling not capped as written");
    silence_now_a: assert property (@(posedge clock) disable iff (!rst_n)
        agc_speech_mode && !speech_target && (five.to_silence_debounce == 3'h0)
        |=> !agc_speech_mode)
        else $error("silence change delayed with zero debounce");
    speech_now_a: assert property (@(posedge clock) disable iff (!rst_n)
        !agc_speech_mode && speech_target && (five.to_speech_debounce == 3'h0)
        |=> agc_speech_mode)
        else $error("speech change delayed with zero debounce");
    no_ramp_a: assert property (@(posedge clock) disable iff (!rst_n)
        five.driver_pop_cut_off && !ramping |=> !ramping)
        else $error("ramp started with pop reduction off");
    unmapped_read_a: assert property (@(posedge clock) disable iff (!rst_n)
        reg_read && !(hit_frac || hit_four || hit_five) |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
endmodule : audio_pll_agc_control_regs
`default_nettype wire

//--- design/driver_ramp.sv
// Output driver ramp timer: counts the pop-reduction ramp after power-up.
// Assumes a 200 MHz clock and a one-cycle start pulse.
`timescale 1ns/1ps
`default_nettype none
`include "audio_ctrl_defs.svh"
module driver_ramp
    import audio_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Control
    input wire logic start,
    input wire logic pop_cut_off,
    input wire logic long_ramp,
    input wire logic virtual_ground,
    // Status
    output logic ramping
);
    localparam logic [31:0] US_SHORT = 32'(`RAMP_SHORT_US);
    localparam logic [31:0] US_LONG = 32'(`RAMP_LONG_US);
    localparam logic [31:0] US_SHORT_NV = 32'(`RAMP_SHORT_NOVG_US);
    localparam logic [31:0] US_LONG_NV = 32'(`RAMP_LONG_NOVG_US);
    localparam logic [7:0] US_TICKS = 8'(`US_CYCLES);

    ramp_state_t state;
    logic [7:0] tick;
    logic [31:0] us_left;
    wire logic us_pulse = (tick == US_TICKS - 8'h01);
    wire logic [31:0] ramp_us = virtual_ground ? (long_ramp ? US_LONG : US_SHORT)
                                               : (long_ramp ? US_LONG_NV : US_SHORT_NV);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state <= RAMP_IDLE;
            tick <= 8'h00;
            us_left <= 32'h0;
        end else begin
            tick <= us_pulse ? 8'h00 : tick + 8'h01;
            case (state)
                RAMP_IDLE, RAMP_DONE: begin
                    if (start && !pop_cut_off) begin
                        state <= RAMP_RUN;
                        us_left <= ramp_us;
                    end
                end
                RAMP_RUN: begin
                    if (us_pulse) begin
                        us_left <= us_left - 32'h1;
                        if (us_left == 32'h1)
                            state <= RAMP_DONE;
                    end
                end
                default: state <= RAMP_IDLE;
            endcase
        end
    end

    assign ramping = (state == RAMP_RUN);
endmodule : driver_ramp
`default_nettype wire

//--- test/audio_pll_agc_control_regs_bench.sv
// Self-checking bench for the audio PLL fraction and AGC/driver control bank.
// Assumes the design's word strobes and the 200 MHz clock; drives every port itself.
`timescale 1ns/1ps
`default_nettype none
`include "audio_ctrl_defs.svh"
module audio_pll_agc_control_regs_bench;
    logic clock, rst_n, reg_write, reg_read, reg_rvalid, pll_enable, short_raw;
    logic playback_pop_active, driver_power_up, virtual_ground, agc_speech_now;
    logic agc_speech_mode, driver_powerdown, short_seen_flag, driver_ramping;
    logic [6:0] reg_addr, gain_ctrl_ceiling;
    logic [15:0] reg_wdata, reg_rdata, v, w;
    logic [13:0] pll_fraction;
    logic [3:0] step_off;
    logic [1:0] page_marker, gain_ctrl_hysteresis;
    logic [2:0] playback_pop_cfg;
    logic [15:0] frac_corner [5] = '{16'h9C3C, 16'h9C40, 16'hFFFC, 16'h0000, 16'h0004};
    int errors = 0;
    int num_checks = 0;
    audio_pll_agc_control_regs DUT (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .pll_enable(pll_enable),
        .page_marker(page_marker), .short_raw(short_raw),
        .playback_pop_active(playback_pop_active), .driver_power_up(driver_power_up),
        .virtual_ground(virtual_ground), .agc_speech_now(agc_speech_now),
        .pll_fraction(pll_fraction), .step_off(step_off),
        .gain_ctrl_hysteresis(gain_ctrl_hysteresis), .gain_ctrl_ceiling(gain_ctrl_ceiling),
        .agc_speech_mode(agc_speech_mode), .driver_powerdown(driver_powerdown),
        .short_seen_flag(short_seen_flag), .playback_pop_cfg(playback_pop_cfg),
        .driver_ramping(driver_ramping));
    always #2.5 clock = ~clock;
    function automatic logic [15:0] frac_exp(input logic [15:0] d, input logic en);
        if (!en) return 16'h0000;
        return (d[15:2] > `FRACTION_MAX) ? {2'h0, `FRACTION_MAX} : {2'h0, d[15:2]};
    endfunction : frac_exp
    // Read-only bits come from live status; reserved bit 11 always zero
    function automatic logic [15:0] four_exp(input logic [15:0] d, input logic sh,
            input logic pop, input logic [1:0] pm);
        return {d[15:12], 1'b0, d[10:7], sh & ~d[8], pop, d[4:2], pm};
    endfunction : four_exp
    task automatic conclude;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge clock);
        reg_write = 1'b0;
    endtask : wr
    task automatic rdc(input string what, input logic [6:0] a, input logic [15:0] exp);
        int n;
        @(negedge clock);
        reg_addr = a;
        reg_read = 1'b1;
        @(negedge clock);
        reg_read = 1'b0;
        n = 0;
        while (reg_rvalid !== 1'b1 && n < 4) begin
            @(negedge clock);
            n++;
        end
        if (reg_rvalid !== 1'b1) begin
            errors++;
            conclude();
        end else begin
            chk(what, exp, reg_rdata);
        end
    endtask : rdc
    // Outputs follow a write two cycles later; a few extra for status paths
    task automatic settle(input int n);
        repeat (n) @(negedge clock);
    endtask : settle
    task automatic pulse_power_up;
        @(negedge clock);
        driver_power_up = 1'b1;
        @(negedge clock);
        driver_power_up = 1'b0;
    endtask : pulse_power_up
    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        conclude();
    end
    initial begin
        {clock, rst_n, reg_write, reg_read, pll_enable, short_raw} = '0;
        {playback_pop_active, driver_power_up, agc_speech_now} = '0;
        reg_addr = 7'h00;
        reg_wdata = 16'h0000;
        page_marker = 2'h2;
        virtual_ground = 1'b1;
        void'($urandom(32'h258F));
        repeat (8) @(negedge clock);
        rst_n = 1'b1;
        chk("ceiling_reset", 16'h0077, {9'h0, gain_ctrl_ceiling});
        rdc("frac_reset", `ADDR_PLL_FRACTION, 16'h0000);
        rdc("four_reset", `ADDR_CTRL_FOUR, 16'h0002);
        rdc("five_reset", `ADDR_CTRL_FIVE, 16'hFE00);
        // Low two bits stay zero on the way in, as software must
        for (int i = 0; i < 12; i++) begin
            v = (i < 5) ? frac_corner[i] : ($urandom() & 16'hFFFC);
            pll_enable = (i == 3) ? 1'b0 : ((i < 5) ? 1'b1 : 1'($urandom()));
            wr(`ADDR_PLL_FRACTION, v);
            settle(3);
            chk("pll_fraction", frac_exp(v, pll_enable), {2'h0, pll_fraction});
            rdc("frac_read", `ADDR_PLL_FRACTION, v);
        end
        // Bit 7 kept clear here so no power-down latches
        for (int i = 0; i < 10; i++) begin
            w = $urandom() & 16'hFF7F;
            if (i < 4) w[10:9] = 2'(i);
            short_raw = 1'($urandom());
            playback_pop_active = 1'($urandom());
            page_marker = 2'($urandom());
            wr(`ADDR_CTRL_FOUR, w);
            settle(3);
            chk("step_off", {12'h0, w[15:12]}, {12'h0, step_off});
            chk("hysteresis", {14'h0, w[10:9]}, {14'h0, gain_ctrl_hysteresis});
            chk("pop_cfg", {13'h0, w[4:2]}, {13'h0, playback_pop_cfg});
            chk("short_flag", {15'h0, short_raw & ~w[8]}, {15'h0, short_seen_flag});
            chk("powerdown", 16'h0000, {15'h0, driver_powerdown});
            rdc("four_read", `ADDR_CTRL_FOUR,
                four_exp(w, short_raw, playback_pop_active, page_marker));
        end
        for (int i = 0; i < 10; i++) begin
            w = (i == 0) ? 16'hEE00 : ((i == 1) ? 16'hF000 : ($urandom() & 16'hFFFE));
            wr(`ADDR_CTRL_FIVE, w);
            settle(3);
            chk("ceiling", {9'h0, (w[15:9] > `CEILING_MAX) ? `CEILING_MAX : w[15:9]},
                {9'h0, gain_ctrl_ceiling});
            rdc("five_read", `ADDR_CTRL_FIVE, w);
        end
        wr(7'h1F, 16'hFFFF);
        rdc("unmapped", 7'h1F, 16'h0000);
        rdc("five_kept", `ADDR_CTRL_FIVE, w);
        // Silence debounce slow, speech debounce zero: proves the two fields apart
        wr(`ADDR_CTRL_FIVE, 16'hFE40);
        agc_speech_now = 1'b1;
        settle(20);
        chk("to_speech", 16'h0001, {15'h0, agc_speech_mode});
        agc_speech_now = 1'b0;
        settle(20);
        chk("to_silence", 16'h0001, {15'h0, agc_speech_mode});
        wr(`ADDR_CTRL_FIVE, 16'hFE08);
        settle(3);
        chk("silence_fast", 16'h0000, {15'h0, agc_speech_mode});
        short_raw = 1'b1;
        playback_pop_active = 1'b0;
        wr(`ADDR_CTRL_FOUR, 16'h0080);
        settle(4);
        chk("short_seen", 16'h0001, {15'h0, short_seen_flag});
        chk("auto_pd", 16'h0001, {15'h0, driver_powerdown});
        rdc("four_short", `ADDR_CTRL_FOUR, {14'h0030, page_marker});
        wr(`ADDR_CTRL_FOUR, 16'h0180);
        settle(4);
        chk("detect_off", 16'h0000, {15'h0, short_seen_flag});
        short_raw = 1'b0;
        wr(`ADDR_CTRL_FIVE, 16'hFE04);
        pulse_power_up();
        settle(4);
        chk("pd_cleared", 16'h0000, {15'h0, driver_powerdown});
        chk("no_ramp", 16'h0000, {15'h0, driver_ramping});
        // Low ceiling here so the reset below has something to undo
        wr(`ADDR_CTRL_FIVE, 16'h2000);
        pulse_power_up();
        settle(4);
        chk("ramp_on", 16'h0001, {15'h0, driver_ramping});
        chk("ceiling_low", 16'h0010, {9'h0, gain_ctrl_ceiling});
        rst_n = 1'b0;
        settle(2);
        rst_n = 1'b1;
        chk("ceiling_rereset", 16'h0077, {9'h0, gain_ctrl_ceiling});
        rdc("five_rereset", `ADDR_CTRL_FIVE, 16'hFE00);
        conclude();
    end
endmodule : audio_pll_agc_control_regs_bench
`default_nettype wire
